// *** pkg/pll_bw_params.svh ***
// Register offsets, field positions, reset values and lock detector counts
`ifndef PLL_BW_PARAMS_SVH
`define PLL_BW_PARAMS_SVH
`define ADDR_LOOP_CTRL 8'h36
`define ADDR_BW_CTRL 8'h37
`define ADDR_MULT_HIGH 8'h38
`define ADDR_MULT_LOW 8'h39
`define ADDR_LIN_RANGE 8'h3A
`define CTRL_IRQ_EN_BIT 7
`define CTRL_FLAG_BIT 6
`define CTRL_POWER_BIT 5
`define CTRL_BASE_SEL_BIT 4
`define CTRL_RANGE_LSB 0
`define BW_AUTO_BIT 7
`define BW_LOCK_BIT 6
`define BW_MODE_BIT 5
`define RST_IRQ_EN 1'b0
`define RST_POWER 1'b1
`define RST_BASE_SEL 1'b0
`define RST_RANGE_EXP 2'h0
`define RST_AUTO 1'b0
`define RST_MULT_HIGH 4'h0
`define RST_MULT_LOW 8'h40
`define RST_LIN_RANGE 8'h40
`define LOCK_WINDOW 8'h10
`define MODE_TOLERANCE 8'h02
`define LOCK_TOLERANCE 8'h01
`endif

// *** pkg/pll_bw_pkg.sv ***
// Types shared by the loop bandwidth control block
package pll_bw_pkg;
  typedef enum logic [2:0] {SEL_CTRL, SEL_BW, SEL_MHIGH, SEL_MLOW, SEL_RANGE, SEL_NONE} reg_sel_t;
  typedef enum {FILT_ACQUIRE, FILT_TRACK} filter_mode_t;
endpackage

// *** design/pll_bandwidth_mode_control.sv ***
// Loop filter bandwidth control, lock detector and loop programming registers
`timescale 1ns/1ps
`include "pll_bw_params.svh"

// Functional notes
// - Acquisition mode: mode bit reads zero, filter allowed large corrections
// - Tracking mode whenever not acquiring or mode bit set; small corrections only
// - With automatic select set, lock detector switches filter mode itself
// - Automatic mode: mode bit read-only, set in tolerance, cleared outside
// - Automatic mode: lock flag read-only, follows frequency entering/leaving tolerance
// - Automatic mode with irq enable: interrupt on every lock flag toggle
// - Manual mode: mode bit is writable and selects acquisition or tracking
// - Manual mode: lock flag held inactive, no interrupts produced
// - Loop output is N times reference; bus clock is quarter of it
// - Centre frequency is L times two to E times nominal step
// - Multiplier value zero behaves exactly as one
// - Linear range zero disables loop and forces crystal base clock
module pll_bandwidth_mode_control
  import pll_bw_pkg::*;
#(
  parameter logic [7:0] MULT_LOW_RST = `RST_MULT_LOW,
  parameter logic [7:0] LIN_RANGE_RST = `RST_LIN_RANGE,
  parameter logic [7:0] LOCK_WIN = `LOCK_WINDOW
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  input wire logic REF_TICK,
  input wire logic FB_TICK,
  output logic LOOP_ENABLE,
  output logic FILTER_TRACK,
  output logic BASE_CLK_SEL,
  output logic [11:0] MULT_N_EFF,
  output logic [1:0] RANGE_EXP,
  output logic [7:0] LIN_RANGE,
  output logic LOCKED,
  output logic IRQ
);

  // Programmable register state
  logic loop_irq_enable_r;
  logic loop_flag_r;
  logic loop_power_on_r;
  logic base_clock_select_r;
  logic [1:0] range_exponent_field_r;
  logic auto_select_r;
  logic lock_r;
  logic filter_mode_select_r;
  logic [3:0] multiplier_high_r;
  logic [7:0] multiplier_low_r;
  logic [7:0] linear_range_r;
  // Lock detector working state
  logic [7:0] ref_cnt_r;
  logic [7:0] fb_cnt_r;
  // Derived loop status
  logic loop_active;
  logic window_end;
  logic [7:0] freq_err;
  logic in_mode_tol;
  logic in_lock_tol;
  logic lock_nxt;
  // Register bus decode
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  filter_mode_t filter_mode;

  // Address decode shared by reads and writes
  function automatic reg_sel_t decode(input logic [7:0] a);
    unique case (a)
      `ADDR_LOOP_CTRL: decode = SEL_CTRL;
      `ADDR_BW_CTRL: decode = SEL_BW;
      `ADDR_MULT_HIGH: decode = SEL_MHIGH;
      `ADDR_MULT_LOW: decode = SEL_MLOW;
      `ADDR_LIN_RANGE: decode = SEL_RANGE;
      default: decode = SEL_NONE;
    endcase
  endfunction

  assign wr_sel = WR_STB ? decode(ADDR) : SEL_NONE;
  assign rd_sel = RD_STB ? decode(ADDR) : SEL_NONE;

  // Loop runs only when powered and range is nonzero
  assign loop_active = loop_power_on_r && (linear_range_r != 8'h00);

  // Filter mode follows the mode bit
  assign filter_mode = filter_mode_select_r ? FILT_TRACK : FILT_ACQUIRE;

  // Frequency error over one reference window
  assign window_end = REF_TICK && (ref_cnt_r == LOCK_WIN - 8'h01);
  assign freq_err = (fb_cnt_r > LOCK_WIN) ? (fb_cnt_r - LOCK_WIN) : (LOCK_WIN - fb_cnt_r);
  assign in_mode_tol = freq_err <= `MODE_TOLERANCE;
  assign in_lock_tol = freq_err <= `LOCK_TOLERANCE;

  // Next lock state: only meaningful in automatic mode with an active loop
  always_comb begin
    lock_nxt = lock_r;
    if (!auto_select_r || !loop_active) begin
      lock_nxt = 1'b0;
    end else if (window_end) begin
      lock_nxt = in_lock_tol;
    end
  end

  // Reference window counter, restarts at each window end
  always_ff @(posedge CLK) begin
    if (RST || !loop_active || window_end) begin
      ref_cnt_r <= 8'h00;
    end else if (REF_TICK) begin
      ref_cnt_r <= ref_cnt_r + 8'h01;
    end
  end

  // Feedback edge counter, saturates so a runaway loop cannot wrap
  always_ff @(posedge CLK) begin
    if (RST || !loop_active) begin
      fb_cnt_r <= 8'h00;
    end else if (window_end) begin
      fb_cnt_r <= FB_TICK ? 8'h01 : 8'h00;
    end else if (FB_TICK && fb_cnt_r != 8'hFF) begin
      fb_cnt_r <= fb_cnt_r + 8'h01;
    end
  end

  // Loop control register with power and base clock interlocks
  always_ff @(posedge CLK) begin
    if (RST) begin
      loop_irq_enable_r <= `RST_IRQ_EN;
      loop_power_on_r <= `RST_POWER;
      base_clock_select_r <= `RST_BASE_SEL;
      range_exponent_field_r <= `RST_RANGE_EXP;
    end else begin
      if (wr_sel == SEL_CTRL) begin
        loop_irq_enable_r <= WR_DATA[`CTRL_IRQ_EN_BIT];
        range_exponent_field_r <= WR_DATA[`CTRL_RANGE_LSB +: 2];
        // Cannot power down while loop clock is selected
        loop_power_on_r <= WR_DATA[`CTRL_POWER_BIT] || base_clock_select_r;
        // Loop clock selectable only if loop already running
        base_clock_select_r <= WR_DATA[`CTRL_BASE_SEL_BIT] && loop_active;
      end
      if (linear_range_r == 8'h00) begin
        base_clock_select_r <= 1'b0;
      end
    end
  end

  // Bandwidth control: automatic select and mode bit
  always_ff @(posedge CLK) begin
    if (RST) begin
      auto_select_r <= `RST_AUTO;
      filter_mode_select_r <= 1'b0;
    end else begin
      if (wr_sel == SEL_BW) begin
        auto_select_r <= WR_DATA[`BW_AUTO_BIT];
      end
      if (auto_select_r) begin
        if (!loop_active) begin
          filter_mode_select_r <= 1'b0;
        end else if (window_end) begin
          filter_mode_select_r <= in_mode_tol;
        end
      end else if (wr_sel == SEL_BW) begin
        filter_mode_select_r <= WR_DATA[`BW_MODE_BIT];
      end
    end
  end

  // Lock flag
  always_ff @(posedge CLK) begin
    if (RST) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // Toggle event flag; set wins over read clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      loop_flag_r <= 1'b0;
    end else if (auto_select_r && (lock_nxt != lock_r)) begin
      loop_flag_r <= 1'b1;
    end else if (rd_sel == SEL_CTRL || !auto_select_r) begin
      loop_flag_r <= 1'b0;
    end
  end

  // Multiplier high nibble
  always_ff @(posedge CLK) begin
    if (RST) begin
      multiplier_high_r <= `RST_MULT_HIGH;
    end else if (wr_sel == SEL_MHIGH) begin
      multiplier_high_r <= WR_DATA[3:0];
    end
  end

  // Multiplier low byte
  always_ff @(posedge CLK) begin
    if (RST) begin
      multiplier_low_r <= MULT_LOW_RST;
    end else if (wr_sel == SEL_MLOW) begin
      multiplier_low_r <= WR_DATA;
    end
  end

  // Linear range; zero here shuts the loop down
  always_ff @(posedge CLK) begin
    if (RST) begin
      linear_range_r <= LIN_RANGE_RST;
    end else if (wr_sel == SEL_RANGE) begin
      linear_range_r <= WR_DATA;
    end
  end

  // Registered read data, zero for unmapped or idle
  always_ff @(posedge CLK) begin
    if (RST) begin
      RD_DATA <= 8'h00;
    end else begin
      unique case (rd_sel)
        SEL_CTRL: RD_DATA <= {loop_irq_enable_r, loop_flag_r, loop_power_on_r, base_clock_select_r,
                              2'h0, range_exponent_field_r};
        SEL_BW: RD_DATA <= {auto_select_r, lock_r, filter_mode_select_r, 5'h00};
        SEL_MHIGH: RD_DATA <= {4'h0, multiplier_high_r};
        SEL_MLOW: RD_DATA <= multiplier_low_r;
        SEL_RANGE: RD_DATA <= linear_range_r;
        SEL_NONE: RD_DATA <= 8'h00;
      endcase
    end
  end

  // Loop enable and base clock select to the clock selector
  always_ff @(posedge CLK) begin
    if (RST) begin
      LOOP_ENABLE <= 1'b0;
      BASE_CLK_SEL <= 1'b0;
    end else begin
      LOOP_ENABLE <= loop_active;
      BASE_CLK_SEL <= base_clock_select_r && loop_active;
    end
  end

  // Filter bandwidth control to the analog loop filter
  always_ff @(posedge CLK) begin
    if (RST) begin
      FILTER_TRACK <= 1'b0;
    end else begin
      FILTER_TRACK <= (filter_mode == FILT_TRACK);
    end
  end

  // Divider of N sets loop output to N times reference
  always_ff @(posedge CLK) begin
    if (RST) begin
      MULT_N_EFF <= 12'h001;
    end else begin
      MULT_N_EFF <= ({multiplier_high_r, multiplier_low_r} == 12'h000) ? 12'h001
                    : {multiplier_high_r, multiplier_low_r};
    end
  end

  // Range exponent and linear range to the oscillator
  always_ff @(posedge CLK) begin
    if (RST) begin
      RANGE_EXP <= 2'h0;
      LIN_RANGE <= 8'h00;
    end else begin
      RANGE_EXP <= range_exponent_field_r;
      LIN_RANGE <= linear_range_r;
    end
  end

  // Lock status copy for the clock selector
  always_ff @(posedge CLK) begin
    if (RST) begin
      LOCKED <= 1'b0;
    end else begin
      LOCKED <= lock_r;
    end
  end

  // Interrupt level, quiet in manual mode
  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= loop_flag_r && loop_irq_enable_r && auto_select_r;
    end
  end

endmodule

// *** testbench/pll_bw_checker.sv ***
// Port assertions for the loop bandwidth control block
`timescale 1ns/1ps
`include "pll_bw_params.svh"
module pll_bw_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic LOOP_ENABLE,
  input wire logic FILTER_TRACK,
  input wire logic BASE_CLK_SEL,
  input wire logic [11:0] MULT_N_EFF,
  input wire logic [7:0] LIN_RANGE,
  input wire logic LOCKED,
  input wire logic IRQ
);
  logic auto_r;
  logic ien_r;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Shadow of automatic select and interrupt enable
  always_ff @(posedge CLK) begin
    if (RST) begin
      auto_r <= 1'b0;
      ien_r <= 1'b0;
    end else if (WR_STB && ADDR == `ADDR_BW_CTRL) begin
      auto_r <= WR_DATA[`BW_AUTO_BIT];
    end else if (WR_STB && ADDR == `ADDR_LOOP_CTRL) begin
      ien_r <= WR_DATA[`CTRL_IRQ_EN_BIT];
    end
  end
  a_n_never_zero: assert property (MULT_N_EFF != 12'h000)
    else $error("multiplier is zero");
  a_range_zero_loop: assert property (LIN_RANGE == 8'h00 |-> !LOOP_ENABLE)
    else $error("loop on with zero range");
  a_range_zero_base: assert property (LIN_RANGE == 8'h00 |-> !BASE_CLK_SEL)
    else $error("loop clock with zero range");
  a_manual_quiet: assert property ((!auto_r)[*3] |-> !IRQ && !LOCKED)
    else $error("lock or irq in manual");
  a_lock_in_track: assert property (LOCKED |-> FILTER_TRACK)
    else $error("locked while acquiring");
  a_reset_clear: assert property ($fell(RST) |-> !LOCKED && !FILTER_TRACK)
    else $error("indicators set after reset");
  a_irq_cause: assert property ($rose(IRQ) |-> $past(auto_r) && $past(ien_r))
    else $error("irq without auto and enable");
  a_irq_on_toggle: assert property ($changed(LOCKED) && $past(auto_r) && $past(ien_r) |-> IRQ)
    else $error("lock toggle without irq");
endmodule
bind pll_bandwidth_mode_control pll_bw_checker i_pll_bw_checker (.CLK(CLK), .RST(RST), .ADDR(ADDR),
  .WR_DATA(WR_DATA), .WR_STB(WR_STB), .LOOP_ENABLE(LOOP_ENABLE), .FILTER_TRACK(FILTER_TRACK),
  .BASE_CLK_SEL(BASE_CLK_SEL), .MULT_N_EFF(MULT_N_EFF), .LIN_RANGE(LIN_RANGE), .LOCKED(LOCKED), .IRQ(IRQ));

// *** testbench/test_pll_bandwidth_mode_control.sv ***
// Self-checking bench for the loop bandwidth control block
`timescale 1ns/1ps
`include "pll_bw_params.svh"
module test_pll_bandwidth_mode_control;
  logic CLK = 0, RST = 1, WR_STB = 0, RD_STB = 0, REF_TICK = 0, FB_TICK = 0;
  logic [7:0] ADDR = 0, WR_DATA = 0, RD_DATA, LIN_RANGE;
  logic LOOP_ENABLE, FILTER_TRACK, BASE_CLK_SEL, LOCKED, IRQ;
  logic [11:0] MULT_N_EFF;
  logic [1:0] RANGE_EXP;
  int bad_count = 0, checks = 0;
  pll_bandwidth_mode_control i_pll_bandwidth_mode_control (.CLK, .RST, .ADDR, .WR_DATA, .WR_STB, .RD_STB,
    .RD_DATA, .REF_TICK, .FB_TICK, .LOOP_ENABLE, .FILTER_TRACK, .BASE_CLK_SEL, .MULT_N_EFF, .RANGE_EXP,
    .LIN_RANGE, .LOCKED, .IRQ);
  // 40 MHz clock
  initial forever #12.5 CLK = ~CLK;
  // Compare and count
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      bad_count++;
    end
  endtask
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLK);
    WR_STB <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK);
    RD_STB <= 1'b0;
    #1 chk({4'h0, RD_DATA}, {4'h0, exp});
  endtask
  task automatic settle;
    repeat (2) @(posedge CLK);
    #1;
  endtask
  // One detector window of reference ticks with n_fb feedback ticks
  task automatic window(input int n_fb);
    for (int i = 0; i < `LOCK_WINDOW + 4; i++) begin
      @(posedge CLK);
      FB_TICK <= i < n_fb;
      REF_TICK <= i >= 4;
    end
    @(posedge CLK);
    REF_TICK <= 1'b0;
    FB_TICK <= 1'b0;
    settle();
  endtask
  task automatic scn_mult;
    wr(`ADDR_MULT_HIGH, 8'h00);
    wr(`ADDR_MULT_LOW, 8'h00);
    settle();
    chk(MULT_N_EFF, 12'h001);
    wr(`ADDR_MULT_HIGH, 8'h01);
    wr(`ADDR_MULT_LOW, 8'h04);
    wr(`ADDR_LOOP_CTRL, 8'hA2);
    settle();
    chk(MULT_N_EFF, 12'h104);
    chk({10'h0, RANGE_EXP}, 12'h002);
  endtask
  task automatic scn_range;
    wr(`ADDR_LIN_RANGE, 8'h00);
    settle();
    chk({3'h0, LOOP_ENABLE, LIN_RANGE}, 12'h000);
    wr(`ADDR_LOOP_CTRL, 8'hB2);
    settle();
    chk({11'h0, BASE_CLK_SEL}, 12'h000);
    wr(`ADDR_LIN_RANGE, 8'h46);
    settle();
    chk({3'h0, LOOP_ENABLE, LIN_RANGE}, 12'h146);
  endtask
  task automatic scn_manual;
    wr(`ADDR_LOOP_CTRL, 8'h82);
    wr(`ADDR_BW_CTRL, 8'h00);
    wr(`ADDR_LOOP_CTRL, 8'hA2);
    window(16);
    wr(`ADDR_BW_CTRL, 8'h20);
    settle();
    chk({11'h0, FILTER_TRACK}, 12'h001);
    window(16);
    chk({10'h0, LOCKED, IRQ}, 12'h000);
    rd(`ADDR_BW_CTRL, 8'h20);
    wr(`ADDR_LOOP_CTRL, 8'hB2);
    settle();
    chk({10'h0, LOOP_ENABLE, BASE_CLK_SEL}, 12'h003);
    wr(`ADDR_LOOP_CTRL, 8'h92);
    settle();
    chk({10'h0, LOOP_ENABLE, BASE_CLK_SEL}, 12'h003);
    wr(`ADDR_LOOP_CTRL, 8'hA2);
    wr(`ADDR_BW_CTRL, 8'h00);
    settle();
    chk({10'h0, FILTER_TRACK, BASE_CLK_SEL}, 12'h000);
  endtask
  task automatic scn_auto;
    wr(`ADDR_BW_CTRL, 8'h80);
    window(16);
    chk({9'h0, LOCKED, FILTER_TRACK, IRQ}, 12'h007);
    rd(`ADDR_BW_CTRL, 8'hE0);
    rd(`ADDR_LOOP_CTRL, 8'hE2);
    wr(`ADDR_BW_CTRL, 8'h80);
    settle();
    chk({10'h0, FILTER_TRACK, IRQ}, 12'h002);
    window(18);
    chk({9'h0, LOCKED, FILTER_TRACK, IRQ}, 12'h003);
    rd(`ADDR_LOOP_CTRL, 8'hE2);
    window(19);
    chk({9'h0, LOCKED, FILTER_TRACK, IRQ}, 12'h000);
  endtask
  task automatic end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    rd(`ADDR_BW_CTRL, 8'h00);
    scn_mult();
    scn_range();
    scn_manual();
    scn_auto();
    end_of_test();
  end
  // Hang guard
  initial begin
    #1000000;
    bad_count++;
    end_of_test();
  end
endmodule
